// *** hw/eirq_ctrl.sv ***
// Purpose: External request pins, their flags and the vector call timing.
// Assumes: APB slave with zero wait states; pins synchronous to core_clk.
// Notes:   Pin 0 outranks pin 1; other sources arrive as higher_busy.
//
// Operation
// - Flags are polled every cycle; an unserved level request is not remembered.
// - The vector long call lasts four clock cycles.
// - Service starts no sooner than five cycles after the flag is set.
// - Single-source response stays within sixteen cycles of activation.
// - Polling outside an instruction's last cycle defers the call.
// - Type bits 0 and 2 pick level (0) or falling edge (1).
// - Edge mode samples each pin every clock; high then low sets flag.
// - Edge flags (bits 1, 3) stay set until software or service entry.
// - Level flags equal the inverted pin; service entry leaves them.
// - Level flags are read-only; edge flags are read and write.
// - A level-mode pin still low after return raises a further request.
// - Activity on either pin wakes the device from power-down.
// - Call only if no equal/higher service, last cycle, no control write.
//
// Register access over APB was decided locally.
`default_nettype none

module eirq_ctrl (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                ext_request_pin_0,
  input  wire logic                ext_request_pin_1,
  input  wire eirq_pkg::eirq_core_s core_in,
  input  wire logic                power_down,
  output logic                     vector_long_call,
  output logic                     service_entry,
  output logic                     service_vector,
  output logic                     wake_req,
  output logic                     irq
);

  // ********************************************************************
  // APB decode.
  // ********************************************************************
  logic        setup_ph;
  logic        access_ph;
  logic        hit_ctrl;
  logic        hit_en;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_core;
  logic        hit_any;
  logic        wr_ctrl;
  logic        wr_en_reg;
  logic        wr_mask;
  logic        rd_stat;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;

  // Zero wait states: every access completes in its first access cycle.
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_ctrl  = (paddr == eirq_pkg::OFF_TIMER_EXT_INT_CONTROL);
  assign hit_en    = (paddr == eirq_pkg::OFF_SRC_ENABLE);
  assign hit_stat  = (paddr == eirq_pkg::OFF_EVT_STATUS);
  assign hit_mask  = (paddr == eirq_pkg::OFF_EVT_MASK);
  assign hit_core  = (paddr == eirq_pkg::OFF_CORE_STATUS);
  assign hit_any   = hit_ctrl | hit_en | hit_stat | hit_mask | hit_core;
  assign wr_ctrl   = access_ph & pwrite & hit_ctrl;
  assign wr_en_reg = access_ph & pwrite & hit_en;
  assign wr_mask   = access_ph & pwrite & hit_mask;
  assign rd_stat   = access_ph & ~pwrite & hit_stat;
  assign pready    = 1'b1;
  assign pslverr   = access_ph & ~hit_any;
  assign prdata    = prdata_q;

  // ********************************************************************
  // Control and configuration registers.
  // ********************************************************************
  logic                      type0_q;
  logic                      type1_q;
  logic [1:0]                src_en_q;
  logic [eirq_pkg::EVT_W-1:0] mask_q;

  // Type selects and enables steer the detectors and the poller.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      type0_q  <= eirq_pkg::RST_TYPE;
      type1_q  <= eirq_pkg::RST_TYPE;
      src_en_q <= eirq_pkg::RST_ENABLE;
      mask_q   <= eirq_pkg::RST_MASK;
    end else begin
      if (wr_ctrl) begin
        type0_q <= pwdata[eirq_pkg::BIT_TYPE0];
        type1_q <= pwdata[eirq_pkg::BIT_TYPE1];
      end
      if (wr_en_reg) begin
        src_en_q <= pwdata[1:0];
      end
      if (wr_mask) begin
        mask_q <= pwdata[eirq_pkg::EVT_W-1:0];
      end
    end
  end

  // ********************************************************************
  // Pin detectors.
  // ********************************************************************
  logic flag0;
  logic flag1;
  logic fall0;
  logic fall1;
  logic clr0;
  logic clr1;

  eirq_pin_detect u_pin0 (
    .core_clk (core_clk),
    .rst      (rst),
    .pin      (ext_request_pin_0),
    .type_sel (type0_q),
    .wr_en    (wr_ctrl),
    .wr_val   (pwdata[eirq_pkg::BIT_FLAG0]),
    .hw_clr   (clr0),
    .flag     (flag0),
    .fall_evt (fall0)
  );

  eirq_pin_detect u_pin1 (
    .core_clk (core_clk),
    .rst      (rst),
    .pin      (ext_request_pin_1),
    .type_sel (type1_q),
    .wr_en    (wr_ctrl),
    .wr_val   (pwdata[eirq_pkg::BIT_FLAG1]),
    .hw_clr   (clr1),
    .flag     (flag1),
    .fall_evt (fall1)
  );

  // ********************************************************************
  // Poller and vector call sequencer.
  // ********************************************************************
  eirq_pkg::eirq_state_e state_q;
  eirq_pkg::eirq_state_e state_d;
  logic [1:0] call_cnt_q;
  logic [1:0] active_q;
  logic [1:0] active_d;
  logic       call_vec_q;
  logic       entry_q;
  logic       poll_ok;
  logic       req0;
  logic       req1;
  logic       take;
  logic       call_end;

  // Requests are judged from this cycle's flags only; nothing is queued.
  assign req0 = flag0 & src_en_q[0] & ~active_q[0];
  assign req1 = flag1 & src_en_q[1] & ~(|active_q);

  // The call may only start at an instruction boundary that is safe.
  assign poll_ok = (state_q == eirq_pkg::ST_IDLE) & core_in.last_cycle
                 & ~core_in.writes_ctrl & ~core_in.is_return
                 & ~core_in.higher_busy;
  assign take     = poll_ok & (req0 | req1);
  assign call_end = (state_q == eirq_pkg::ST_CALL)
                  & (call_cnt_q == eirq_pkg::CALL_CNT_LAST);

  // Entering the routine clears only an edge flag.
  assign clr0 = call_end & ~call_vec_q;
  assign clr1 = call_end & call_vec_q;

  // State advance from idle to call and back after four cycles.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      eirq_pkg::ST_IDLE: begin
        if (take) begin
          state_d = eirq_pkg::ST_CALL;
        end
      end
      eirq_pkg::ST_CALL: begin
        if (call_end) begin
          state_d = eirq_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Service bookkeeping; a return frees the highest level in service.
  always_comb begin
    active_d = active_q;
    if (core_in.return_done) begin
      if (active_q[0]) begin
        active_d[0] = 1'b0;
      end else begin
        active_d[1] = 1'b0;
      end
    end
    if (call_end) begin
      active_d[call_vec_q] = 1'b1;
    end
  end

  // The counter runs only while the call is under way.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q    <= eirq_pkg::ST_IDLE;
      call_cnt_q <= 2'h0;
      call_vec_q <= 1'b0;
      active_q   <= 2'h0;
      entry_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      call_cnt_q <= (state_q == eirq_pkg::ST_CALL) ? call_cnt_q + 2'h1 : 2'h0;
      if (take) begin
        call_vec_q <= ~req0; // Pin 0 wins a tie.
      end
      active_q <= active_d;
      entry_q  <= call_end;
    end
  end

  assign vector_long_call = (state_q == eirq_pkg::ST_CALL);
  assign service_entry    = entry_q;
  assign service_vector   = call_vec_q;

  // ********************************************************************
  // Wake-up and event status.
  // ********************************************************************
  logic                       wake_q;
  logic [eirq_pkg::EVT_W-1:0] evt;
  logic [eirq_pkg::EVT_W-1:0] evt_clr;
  logic [eirq_pkg::EVT_W-1:0] status_q;
  logic [eirq_pkg::EVT_W-1:0] status_d;

  // A low level on either pin is the wake activity, whatever the mode.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= power_down & (~ext_request_pin_0 | ~ext_request_pin_1);
    end
  end
  assign wake_req = wake_q;

  assign evt[eirq_pkg::EVT_SET0]  = fall0 & type0_q;
  assign evt[eirq_pkg::EVT_SET1]  = fall1 & type1_q;
  assign evt[eirq_pkg::EVT_ENTRY] = call_end;
  assign evt[eirq_pkg::EVT_WAKE]  = wake_q;

  // Only the bits returned by the read are cleared, so a late event stays.
  assign evt_clr  = rd_stat ? prdata_q[eirq_pkg::EVT_W-1:0] : '0;
  assign status_d = (status_q & ~evt_clr) | evt;
  assign irq      = |(status_q & mask_q);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // ********************************************************************
  // Read data, captured in the setup cycle.
  // ********************************************************************
  assign rd_mux =
      hit_ctrl ? {28'h0, flag1, type1_q, flag0, type0_q} :
      hit_en   ? {30'h0, src_en_q} :
      hit_stat ? {28'h0, status_q} :
      hit_mask ? {28'h0, mask_q} :
      hit_core ? {29'h0, active_q, vector_long_call} : 32'h0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q <= 32'h0;
    end else if (setup_ph) begin
      prdata_q <= pwrite ? 32'h0 : rd_mux;
    end
  end

  // ********************************************************************
  // Checks.
  // ********************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_call_four_cycles: assert property (
    $rose(vector_long_call) |-> vector_long_call[*4] ##1 !vector_long_call)
    else $error("Vector call did not last four cycles.");

  a_entry_after_call: assert property (
    $rose(vector_long_call) |-> ##4 service_entry)
    else $error("Service entry not four cycles after call start.");

  a_min_response: assert property (
    service_entry && !service_vector |-> $past(flag0, 5))
    else $error("Service entered before five cycles from flag set.");

  a_poll_last_cycle: assert property (
    $rose(vector_long_call) |-> $past(core_in.last_cycle))
    else $error("Call started outside an instruction's last cycle.");

  a_call_conditions: assert property (
    $rose(vector_long_call) |->
      $past(!core_in.higher_busy && !core_in.writes_ctrl && !core_in.is_return))
    else $error("Call started while a blocking condition held.");

  a_poll_fresh_flag: assert property (
    $rose(vector_long_call) |->
      $past((flag0 && src_en_q[0]) || (flag1 && src_en_q[1])))
    else $error("Call started without a live request flag.");

  a_level_follow: assert property (
    !type0_q |-> flag0 == !ext_request_pin_0)
    else $error("Level flag does not mirror the inverted pin.");

  a_wake_on_pin: assert property (
    power_down && !ext_request_pin_1 |=> wake_req)
    else $error("Low pin in power-down did not request wake.");

  a_irq_level: assert property (
    |(evt & mask_q) && !wr_mask |=> irq)
    else $error("Unmasked event did not raise the interrupt output.");

  c_edge_entry: cover property (type0_q && service_entry && !service_vector);
  c_level_entry: cover property (!type0_q && service_entry && !service_vector);
  c_wake: cover property ($rose(wake_req));

endmodule // eirq_ctrl

`default_nettype wire

// *** hw/eirq_pin_detect.sv ***
// Purpose: Request flag logic for one external request pin.
// Assumes: Pin is synchronous to core_clk and idles high.
// Notes:   Edge mode keeps a sticky flag; level mode mirrors the inverted pin.
`default_nettype none

module eirq_pin_detect (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin,
  input  wire logic type_sel,
  input  wire logic wr_en,
  input  wire logic wr_val,
  input  wire logic hw_clr,
  output logic      flag,
  output logic      fall_evt
);

  // ********************************************************************
  // Sampling and flag.
  // ********************************************************************
  logic prev_q;
  logic flag_q;
  logic flag_d;
  logic edge_set;

  // A high sample followed by a low one marks a falling edge.
  assign fall_evt = prev_q & ~pin;
  assign edge_set = type_sel & fall_evt;

  // Set wins over both clears; level mode parks the sticky flag at zero.
  assign flag_d = !type_sel ? 1'b0 :
                  edge_set  ? 1'b1 :
                  wr_en     ? wr_val :
                  hw_clr    ? 1'b0 : flag_q;

  // Level mode shows the inverse pin directly and ignores writes.
  assign flag = type_sel ? flag_q : ~pin;

  // Reset the sample to the idle high level, so an idle pin shows no edge after reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_q <= 1'b1;
      flag_q <= 1'b0;
    end else begin
      prev_q <= pin;
      flag_q <= flag_d;
    end
  end

  // ********************************************************************
  // Checks.
  // ********************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_edge_sets_flag: assert property (
    type_sel && $past(pin) && !pin |=> flag || !type_sel)
    else $error("Falling edge did not set the request flag.");

  a_edge_flag_sticky: assert property (
    type_sel && $past(type_sel) && $past(flag) && !flag |->
      $past(wr_en) || $past(hw_clr))
    else $error("Edge flag cleared without a clear request.");

endmodule // eirq_pin_detect

`default_nettype wire

// *** hw/eirq_pkg.sv ***
// Purpose: Shared constants and types for the external request pin block.
// Assumes: Single 10 MHz core clock, synchronous active-high reset.
// Notes:   Register offsets are byte addresses on a 32-bit APB bus.
`default_nettype none

package eirq_pkg;

  // ********************************************************************
  // Register map.
  // ********************************************************************
  localparam logic [7:0] OFF_TIMER_EXT_INT_CONTROL = 8'h88;
  localparam logic [7:0] OFF_SRC_ENABLE            = 8'h8c;
  localparam logic [7:0] OFF_EVT_STATUS            = 8'h90;
  localparam logic [7:0] OFF_EVT_MASK              = 8'h94;
  localparam logic [7:0] OFF_CORE_STATUS           = 8'h98;

  // Field positions in timer_ext_int_control.
  localparam int BIT_TYPE0 = 0;
  localparam int BIT_FLAG0 = 1;
  localparam int BIT_TYPE1 = 2;
  localparam int BIT_FLAG1 = 3;

  // Event status bit positions.
  localparam int EVT_W     = 4;
  localparam int EVT_SET0  = 0;
  localparam int EVT_SET1  = 1;
  localparam int EVT_ENTRY = 2;
  localparam int EVT_WAKE  = 3;

  // Values after reset.
  localparam logic             RST_TYPE   = 1'b0;
  localparam logic [1:0]       RST_ENABLE = 2'h0;
  localparam logic [EVT_W-1:0] RST_MASK   = 4'h0;

  // Timing of the vector call, in core clock cycles.
  localparam int CALL_CYCLES         = 4;
  localparam int MIN_RESPONSE_CYCLES = 5;
  localparam int MAX_RESPONSE_CYCLES = 16;
  localparam logic [1:0] CALL_CNT_LAST = 2'(CALL_CYCLES - 1);

  typedef enum logic {ST_IDLE, ST_CALL} eirq_state_e;

  // Status of the instruction pipeline seen by the poller.
  typedef struct packed {
    logic last_cycle;
    logic writes_ctrl;
    logic is_return;
    logic higher_busy;
    logic return_done;
  } eirq_core_s;

endpackage : eirq_pkg

`default_nettype wire

// *** verification/eirq_src_model.sv ***
// Purpose: Behavioural external request sources for the two pins.
// Assumes: Bench drives the controls on rising edges of core_clk.
// Notes:   Pins idle high; a pulse stays low for one or three clocks.
`default_nettype none

module eirq_src_model (
  input  wire logic       core_clk,
  input  wire logic [1:0] pulse_req,
  input  wire logic [1:0] slow,
  input  wire logic [1:0] hold_low,
  output logic      [1:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // ********************
  // Pin drivers
  // ********************
  logic [1:0] cnt_q [2];

  initial begin
    pins     = 2'h3;
    cnt_q[0] = 2'h0;
    cnt_q[1] = 2'h0;
  end

  // Every low phase spans at least a whole clock, or the sampler could miss it.
  // A level source stays low for as long as the bench holds it.
  always @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (pulse_req[i]) begin
        cnt_q[i] <= slow[i] ? 2'h3 : 2'h1;
      end else if (cnt_q[i] != 2'h0) begin
        cnt_q[i] <= cnt_q[i] - 2'h1;
      end
      pins[i] <= !(hold_low[i] || pulse_req[i] || cnt_q[i] > 2'h1);
    end
  end
endmodule // eirq_src_model

`default_nettype wire

// *** verification/ext_interrupt_pins_and_latency_tb_top.sv ***
// Purpose: Self-checking bench for the external request pin block.
// Assumes: Zero-wait APB slave; pins come from the source model.
// Notes:   Outputs are sampled on falling edges, APB read data and error on rising; inputs set on rising.
`default_nettype none

module ext_interrupt_pins_and_latency_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ********************
  // Signals
  // ********************
  logic                 core_clk   = 1'b0;
  logic                 rst        = 1'b1;
  logic                 psel       = 1'b0;
  logic                 penable    = 1'b0;
  logic                 pwrite     = 1'b0;
  logic [7:0]           paddr      = 8'h00;
  logic [31:0]          pwdata     = 32'h0;
  logic [1:0]           pulse_req  = 2'h0;
  logic [1:0]           slow       = 2'h0;
  logic [1:0]           hold_low   = 2'h0;
  eirq_pkg::eirq_core_s core_in    = 5'h00;
  logic                 power_down = 1'b0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [1:0]           pins;
  logic                 vector_long_call;
  logic                 service_entry;
  logic                 service_vector;
  logic                 wake_req;
  logic                 irq;
  logic [31:0]          rdv;
  logic                 err;
  int                   calls;
  int                   at;
  int                   errors     = 0;
  int                   num_checks = 0;

  // Core clock at 10 MHz.
  always #50 core_clk = ~core_clk;

  eirq_ctrl i_dut (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_request_pin_0(pins[0]),
    .ext_request_pin_1(pins[1]), .core_in(core_in), .power_down(power_down),
    .vector_long_call(vector_long_call), .service_entry(service_entry),
    .service_vector(service_vector), .wake_req(wake_req), .irq(irq)
  );

  eirq_src_model i_src (
    .core_clk(core_clk), .pulse_req(pulse_req), .slow(slow),
    .hold_low(hold_low), .pins(pins)
  );

  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask

  // The request stays put until pready is seen high, so no wait state is assumed.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge core_clk);
    end
    if (pready !== 1'b1) begin
      errors++;
      print_verdict();
    end
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(a, 1'b0, 32'h0);
    chk(nm, exp, rdv);
  endtask

  // Counts call cycles and notes the first service entry over n cycles.
  task automatic run(input int n);
    calls = 0;
    at    = -1;
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      if (vector_long_call === 1'b1) calls++;
      if (service_entry === 1'b1 && at < 0) at = i;
    end
  endtask

  // Returns in the first cycle that the pin is low.
  task automatic fire(input int i, input logic s);
    int n;
    n = 0;
    @(posedge core_clk);
    pulse_req[i] <= 1'b1;
    slow[i]      <= s;
    @(posedge core_clk);
    pulse_req[i] <= 1'b0;
    @(negedge core_clk);
    while (pins[i] !== 1'b0 && n < 4) begin
      n++;
      @(negedge core_clk);
    end
    chk("pin low", 32'h0, {31'h0, pins[i]});
  endtask

  task automatic ret();
    @(posedge core_clk);
    core_in <= 5'h11;
    @(posedge core_clk);
    core_in <= 5'h10;
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    for (int a = 0; a < 5; a++) rd(8'h88 + 8'(4 * a), 32'h0, "reset value");
    apb(8'ha0, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rdv);
  endtask

  task automatic t_level();
    apb(8'h8c, 1'b1, 32'h1);
    @(posedge core_clk);
    core_in     <= 5'h10;
    hold_low[0] <= 1'b1;
    run(8);
    chk("level entry", 32'h6, 32'(at));
    chk("level call", 32'h4, 32'(calls));
    rd(8'h88, 32'h2, "level flag");
    apb(8'h88, 1'b1, 32'ha);
    rd(8'h88, 32'h2, "level write");
    ret();
    run(10);
    chk("level again", 32'h1, {31'h0, at >= 0});
    @(posedge core_clk);
    hold_low[0] <= 1'b0;
    ret();
    rd(8'h88, 32'h0, "level release");
  endtask

  task automatic t_edge();
    apb(8'h88, 1'b1, 32'h5);
    apb(8'h8c, 1'b1, 32'h3);
    apb(8'h90, 1'b0, 32'h0);
    fire(0, 1'b0);
    run(10);
    chk("edge entry", 32'h5, 32'(at));
    chk("edge call", 32'h4, 32'(calls));
    chk("edge vector", 32'h0, {31'h0, service_vector});
    rd(8'h88, 32'h5, "edge flag");
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(8'h94, 1'b1, 32'h4);
    @(negedge core_clk);
    chk("irq set", 32'h1, {31'h0, irq});
    rd(8'h90, 32'h5, "status");
    @(negedge core_clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    rd(8'h90, 32'h0, "status read");
    ret();
  endtask

  task automatic t_soft();
    apb(8'h8c, 1'b1, 32'h0);
    fire(1, 1'b1);
    run(12);
    rd(8'h88, 32'hd, "flag sticky");
    apb(8'h88, 1'b1, 32'h5);
    rd(8'h88, 32'h5, "soft clear");
    apb(8'h88, 1'b1, 32'hf);
    rd(8'h88, 32'hf, "soft set");
    apb(8'h88, 1'b1, 32'h5);
  endtask

  // Both flags wait behind each blocking condition in turn.
  task automatic t_poll();
    @(posedge core_clk);
    core_in <= 5'h00;
    apb(8'h8c, 1'b1, 32'h3);
    fire(1, 1'b0);
    fire(0, 1'b0);
    run(8);
    chk("mid instr", 32'h0, 32'(calls));
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      core_in <= 5'(5'h10 | (5'h08 >> k));
      run(6);
      chk("blocked", 32'h0, 32'(calls));
    end
    @(posedge core_clk);
    core_in <= 5'h10;
    run(8);
    chk("pin0 first", 32'h1, {31'h0, at >= 0 && service_vector === 1'b0});
    ret();
    run(10);
    chk("pin1 next", 32'h1, {31'h0, at >= 0 && service_vector === 1'b1});
    ret();
    rd(8'h88, 32'h5, "entry clears");
  endtask

  task automatic t_forget();
    apb(8'h88, 1'b1, 32'h4);
    @(posedge core_clk);
    core_in     <= 5'h00;
    hold_low[0] <= 1'b1;
    run(4);
    @(posedge core_clk);
    hold_low[0] <= 1'b0;
    run(3);
    @(posedge core_clk);
    core_in <= 5'h10;
    run(8);
    chk("forgotten", 32'h0, 32'(calls));
  endtask

  task automatic t_wake();
    apb(8'h8c, 1'b1, 32'h0);
    @(posedge core_clk);
    power_down <= 1'b1;
    run(3);
    chk("no wake", 32'h0, {31'h0, wake_req});
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      hold_low[i] <= 1'b1;
      run(3);
      chk("wake", 32'h1, {31'h0, wake_req});
      @(posedge core_clk);
      hold_low[i] <= 1'b0;
      run(3);
      chk("wake end", 32'h0, {31'h0, wake_req});
    end
    @(posedge core_clk);
    power_down <= 1'b0;
  endtask

  // ********************
  // Run control
  // ********************
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence after an eight-cycle reset.
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_level();
    t_edge();
    t_soft();
    t_poll();
    t_forget();
    t_wake();
    print_verdict();
  end

  // A hang ends the run as a failure after 20000 cycles.
  initial begin
    #2000000;
    errors++;
    print_verdict();
  end
endmodule // ext_interrupt_pins_and_latency_tb_top

`default_nettype wire
